// ===== logic/adcsq_pkg.sv
// Package for the converter sequencer: register map, field layout and timing.
// Assumes a single 100 MHz bus clock and AXI4-Lite register access.
package adcsq_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADCSQ_OFF_CTRL = 4'h0;
	localparam logic [3:0] ADCSQ_OFF_RESULT = 4'h4;
	localparam logic [3:0] ADCSQ_OFF_CLKCFG = 4'h8;
	// ****************************************
	// Fields of the control and status register
	// ****************************************
	localparam int ADCSQ_BIT_DONE = 7;
	localparam int ADCSQ_BIT_IRQ_EN = 6;
	localparam int ADCSQ_BIT_CONT = 5;
	localparam int ADCSQ_SEL_MSB = 4;
	localparam logic [4:0] ADCSQ_SEL_RST = 5'h1F;
	localparam logic [4:0] ADCSQ_SEL_EXT_MAX = 5'h07;
	localparam logic [4:0] ADCSQ_SEL_REFH = 5'h1D;
	localparam logic [4:0] ADCSQ_SEL_REFL = 5'h1E;
	localparam logic [4:0] ADCSQ_SEL_OFF = 5'h1F;
	// ****************************************
	// Fields of the clock configuration register
	// ****************************************
	localparam int ADCSQ_BIT_CLKSRC = 4;
	localparam int ADCSQ_DIV_MSB = 7;
	localparam int ADCSQ_DIV_LSB = 5;
	localparam logic [7:0] ADCSQ_CLKCFG_RST = 8'h00;
	// ****************************************
	// Timing and bus response codes
	// ****************************************
	localparam logic [4:0] ADCSQ_CONV_CYCLES = 5'h10;
	localparam logic [1:0] ADCSQ_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADCSQ_RESP_SLVERR = 2'h2;
endpackage : adcsq_pkg

// ===== logic/adcsq_clkdiv.sv
// Converter clock enable: picks the source tick and divides it by 1..16.
// Assumes the oscillator tick is a one-cycle pulse already in the bus domain.
`timescale 1ns/1ps
module adcsq_clkdiv
	import adcsq_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Configuration and oscillator tick
	input wire logic i_src_bus,
	input wire logic [2:0] i_div,
	input wire logic i_osc_tick,
	// Converter tick
	output logic o_tick
);
	logic [3:0] cnt_reg;
	logic [3:0] limit;
	logic src_tick;

	// [RULE_17] source select
	assign src_tick = i_src_bus ? 1'b1 : i_osc_tick;
	// [RULE_16] divide ratio decode
	assign limit = i_div[2] ? 4'hF : (i_div[1] ? (i_div[0] ? 4'h7 : 4'h3) : {3'h0, i_div[0]});
	assign o_tick = src_tick && (cnt_reg >= limit);

	// Divider counter, restarts on each output tick
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_reg <= 4'h0;
		end else if (o_tick) begin
			cnt_reg <= 4'h0;
		end else if (src_tick) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule : adcsq_clkdiv

// ===== logic/adcsq_top.sv
// Converter sequencer: control/status, result and clock registers on AXI4-Lite,
// single and continuous conversion sequencing around an external SAR core.
// Assumes the analog core returns a result at its done strobe, stop mode and
// the oscillator tick come from the same clock domain.
// Notes on behaviour
// [RULE_01] Done flag sets per conversion, irq off
// [RULE_02] Flag holds until result read; reset clears
// [RULE_03] Irq enabled: flag never set, reads 0
// [RULE_04] Software writes 0 to flag bit
// [RULE_05] Irq enabled: request at each conversion end
// [RULE_06] Request cleared by result read or control write
// [RULE_07] Reset clears irq enable and continuous mode
// [RULE_08] Continuous mode converts back to back
// [RULE_09] Single mode: one conversion per write
// [RULE_10] Five-bit selector, codes 0-7 external inputs
// [RULE_11] Codes 1D/1E route reference high/low
// [RULE_12] All-ones selector powers converter down
// [RULE_13] First result after power-up needs discarding
// [RULE_14] Reserved selector codes give undefined result
// [RULE_15] One 8-bit result register, updated each conversion
// [RULE_16] Prescaler divides by 1,2,4,8,16
// [RULE_17] Source select: 1 bus clock, 0 oscillator
// [RULE_18] Software aims converter clock near 1 MHz
// [RULE_19] Conversion starts on write, 16-17 ticks
// [RULE_20] Software discards interrupted conversion data
// [RULE_21] Stop mode aborts; resumes after leaving stop
// [RULE_22] Selected pin forced input, reads zero
// [RULE_23] Control write restarts conversion with new settings
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module adcsq_top
	import adcsq_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// AXI4-Lite write address and data
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [3:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [3:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// System
	input wire logic i_osc_tick,
	input wire logic i_stop_mode,
	// Analog core
	output logic o_sample,
	output logic o_core_tick,
	output logic [4:0] o_input_select,
	output logic o_ref_high_sel,
	output logic o_ref_low_sel,
	output logic o_power_down,
	input wire logic [7:0] i_core_result,
	// Port override and interrupt
	output logic [7:0] o_pin_override,
	output logic o_irq
);
	typedef enum logic [2:0] {
		ADCSQ_IDLE = 3'b001,
		ADCSQ_CONV = 3'b010,
		ADCSQ_HALT = 3'b100
	} adcsq_state_t;

	adcsq_state_t state_reg, state_next;
	logic conv_done_flag_reg, conv_irq_en_reg, continuous_conv_sel_reg;
	logic [4:0] input_select_field_reg;
	logic [7:0] conv_result_reg, adc_clk_cfg_reg;
	logic irq_reg;
	logic [4:0] tick_cnt_reg;
	logic [3:0] aw_addr_reg, ar_addr_reg;
	logic aw_held_reg, w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic tick, wr_fire, rd_fire, ctrl_wr, clk_wr, result_rd, conv_end, start;
	logic aw_hs, w_hs, ar_hs, wr_map, rd_map;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] rd_word;
	logic [7:0] ctrl_read;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// Address and data held separately so either may come first
	assign o_awready = !aw_held_reg && !bvalid_reg;
	assign o_wready = !w_held_reg && !bvalid_reg;
	assign aw_hs = i_awvalid && o_awready;
	assign w_hs = i_wvalid && o_wready;
	assign wr_addr = aw_held_reg ? aw_addr_reg : i_awaddr;
	assign wr_data = w_held_reg ? w_data_reg : i_wdata;
	assign wr_fire = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
	assign wr_map = (wr_addr == ADCSQ_OFF_CTRL) || (wr_addr == ADCSQ_OFF_RESULT)
		|| (wr_addr == ADCSQ_OFF_CLKCFG);
	assign ctrl_wr = wr_fire && (wr_addr == ADCSQ_OFF_CTRL)
		&& (w_held_reg ? w_strb_reg[0] : i_wstrb[0]);
	assign clk_wr = wr_fire && (wr_addr == ADCSQ_OFF_CLKCFG)
		&& (w_held_reg ? w_strb_reg[0] : i_wstrb[0]);
	assign o_arready = !rvalid_reg;
	assign ar_hs = i_arvalid && o_arready;
	assign rd_map = (i_araddr == ADCSQ_OFF_CTRL) || (i_araddr == ADCSQ_OFF_RESULT)
		|| (i_araddr == ADCSQ_OFF_CLKCFG);
	assign rd_fire = ar_hs;
	assign result_rd = rd_fire && (i_araddr == ADCSQ_OFF_RESULT);
	// [RULE_03] flag masked when irq enabled
	assign ctrl_read = {conv_done_flag_reg && !conv_irq_en_reg, conv_irq_en_reg,
		continuous_conv_sel_reg, input_select_field_reg};
	assign rd_word = (i_araddr == ADCSQ_OFF_CTRL) ? {24'h0, ctrl_read} :
		(i_araddr == ADCSQ_OFF_RESULT) ? {24'h0, conv_result_reg} :
		(i_araddr == ADCSQ_OFF_CLKCFG) ? {24'h0, adc_clk_cfg_reg} : 32'h0;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;

	// Write channel holding and response
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= ADCSQ_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_map ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
			end else begin
				if (aw_hs) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= i_awaddr;
				end
				if (w_hs) begin
					w_held_reg <= 1'b1;
					w_data_reg <= i_wdata;
					w_strb_reg <= i_wstrb;
				end
				if (bvalid_reg && i_bready) begin
					bvalid_reg <= 1'b0;
				end
			end
		end
	end

	// Read response
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= ADCSQ_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_map ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Done bit of written data is ignored; it is read-only
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// [RULE_07] reset to single mode, irq off
			conv_irq_en_reg <= 1'b0;
			continuous_conv_sel_reg <= 1'b0;
			input_select_field_reg <= ADCSQ_SEL_RST;
			adc_clk_cfg_reg <= ADCSQ_CLKCFG_RST;
		end else begin
			if (ctrl_wr) begin
				conv_irq_en_reg <= wr_data[ADCSQ_BIT_IRQ_EN];
				continuous_conv_sel_reg <= wr_data[ADCSQ_BIT_CONT];
				input_select_field_reg <= wr_data[ADCSQ_SEL_MSB:0];
			end
			if (clk_wr) begin
				adc_clk_cfg_reg <= {wr_data[ADCSQ_DIV_MSB:ADCSQ_DIV_LSB],
					wr_data[ADCSQ_BIT_CLKSRC], 4'h0};
			end
		end
	end

	// [RULE_01] [RULE_02] done flag; set wins over read clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			conv_done_flag_reg <= 1'b0;
		end else if (conv_end && !conv_irq_en_reg) begin
			conv_done_flag_reg <= 1'b1;
		end else if (result_rd || conv_irq_en_reg) begin
			conv_done_flag_reg <= 1'b0;
		end
	end

	// [RULE_05] [RULE_06] interrupt request; a new end wins over clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_reg <= 1'b0;
		end else if (conv_end && conv_irq_en_reg) begin
			irq_reg <= 1'b1;
		end else if (result_rd || ctrl_wr) begin
			irq_reg <= 1'b0;
		end
	end
	assign o_irq = irq_reg;

	// [RULE_15] result captured at each conversion end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			conv_result_reg <= 8'h00;
		end else if (conv_end) begin
			conv_result_reg <= i_core_result;
		end
	end

	// ****************************************
	// Converter clock
	// ****************************************
	adcsq_clkdiv u_clkdiv (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_src_bus(adc_clk_cfg_reg[ADCSQ_BIT_CLKSRC]),
		.i_div(adc_clk_cfg_reg[ADCSQ_DIV_MSB:ADCSQ_DIV_LSB]),
		.i_osc_tick(i_osc_tick),
		.o_tick(tick)
	);
	assign o_core_tick = tick && (state_reg == ADCSQ_CONV);

	// ****************************************
	// Sequencer
	// ****************************************
	// [RULE_19] a conversion is 16 converter ticks
	assign conv_end = (state_reg == ADCSQ_CONV) && tick && (tick_cnt_reg == ADCSQ_CONV_CYCLES - 5'h1)
		&& !ctrl_wr && !i_stop_mode;
	// [RULE_09] [RULE_23] each control write (re)starts unless the new selector is all-ones
	assign start = ctrl_wr && (wr_data[ADCSQ_SEL_MSB:0] != ADCSQ_SEL_OFF);
	assign o_sample = (state_reg == ADCSQ_CONV) && (tick_cnt_reg == 5'h0) && tick;

	// Next state; stop mode wins over everything
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADCSQ_IDLE: begin
				if (start && !i_stop_mode) begin
					state_next = ADCSQ_CONV;
				end
			end
			ADCSQ_CONV: begin
				// [RULE_21] stop aborts pending conversion
				if (i_stop_mode) begin
					state_next = ADCSQ_HALT;
				end else if (ctrl_wr) begin
					state_next = start ? ADCSQ_CONV : ADCSQ_IDLE;
				// [RULE_08] continuous mode goes again
				end else if (conv_end && !continuous_conv_sel_reg) begin
					state_next = ADCSQ_IDLE;
				end
			end
			ADCSQ_HALT: begin
				// Resume with a fresh conversion after stop
				if (!i_stop_mode) begin
					state_next = ADCSQ_CONV;
				end
			end
			default: begin
				state_next = ADCSQ_IDLE;
			end
		endcase
	end

	// State and tick counter
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= ADCSQ_IDLE;
			tick_cnt_reg <= 5'h0;
		end else begin
			state_reg <= state_next;
			if (ctrl_wr || state_reg != ADCSQ_CONV || conv_end || i_stop_mode) begin
				tick_cnt_reg <= 5'h0;
			end else if (tick) begin
				tick_cnt_reg <= tick_cnt_reg + 5'h1;
			end
		end
	end

	// ****************************************
	// Analog routing
	// ****************************************
	// [RULE_10] [RULE_14] selector passed through; reserved codes give no defined value
	assign o_input_select = input_select_field_reg;
	// [RULE_11] reference self-check routing
	assign o_ref_high_sel = (input_select_field_reg == ADCSQ_SEL_REFH);
	assign o_ref_low_sel = (input_select_field_reg == ADCSQ_SEL_REFL);
	// [RULE_12] all-ones powers down; [RULE_13] first result after leaves is unsettled
	assign o_power_down = (input_select_field_reg == ADCSQ_SEL_OFF) || i_stop_mode;

	// [RULE_22] selected port pin forced to input
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			assign o_pin_override[g] = (input_select_field_reg == 5'(g));
		end
	endgenerate

	// ****************************************
	// Checks
	// ****************************************
	property p_flag_irq_off;
		@(posedge i_clk) disable iff (!i_reset_n)
		(conv_end && !conv_irq_en_reg) |=> conv_done_flag_reg;
	endproperty
	a_flag_irq_off: assert property (p_flag_irq_off) else $error("done flag not set"); // [RULE_01]

	property p_flag_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		(conv_done_flag_reg && !result_rd && !conv_irq_en_reg) |=> conv_done_flag_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped"); // [RULE_02]

	property p_flag_masked;
		@(posedge i_clk) disable iff (!i_reset_n)
		(rd_fire && (i_araddr == ADCSQ_OFF_CTRL) && conv_irq_en_reg) |=> !o_rdata[ADCSQ_BIT_DONE];
	endproperty
	a_flag_masked: assert property (p_flag_masked) else $error("flag read 1 with irq"); // [RULE_03]

	property p_irq_set;
		@(posedge i_clk) disable iff (!i_reset_n)
		(conv_end && conv_irq_en_reg) |=> o_irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not raised"); // [RULE_05]

	property p_irq_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		((result_rd || ctrl_wr) && !conv_end) |=> !o_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared"); // [RULE_06]

	property p_cont;
		@(posedge i_clk) disable iff (!i_reset_n)
		(conv_end && continuous_conv_sel_reg && !i_stop_mode) |=> state_reg == ADCSQ_CONV;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous stopped"); // [RULE_08]

	property p_single;
		@(posedge i_clk) disable iff (!i_reset_n)
		(conv_end && !continuous_conv_sel_reg) |=> state_reg == ADCSQ_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("single mode kept going"); // [RULE_09]

	property p_result;
		@(posedge i_clk) disable iff (!i_reset_n)
		conv_end |=> conv_result_reg == $past(i_core_result);
	endproperty
	a_result: assert property (p_result) else $error("result not captured"); // [RULE_15]

	property p_stop;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_stop_mode |=> state_reg != ADCSQ_CONV;
	endproperty
	a_stop: assert property (p_stop) else $error("converting in stop"); // [RULE_21]

	property p_restart;
		@(posedge i_clk) disable iff (!i_reset_n)
		(start && !i_stop_mode) |=> (state_reg == ADCSQ_CONV) && tick_cnt_reg == 5'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart on write"); // [RULE_23]
endmodule : adcsq_top

// ===== bench/adcsq_top_tb.sv
// Self-checking bench for the converter sequencer, driven over AXI4-Lite.
// Assumes the package register map and a 16-tick conversion per the hand-over.
`timescale 1ns/1ps
module adcsq_top_tb;
	import adcsq_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	localparam int OSC_PER = 5;
	logic i_clk = 1'b0, i_reset_n = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0, i_osc_tick = 1'b0, i_stop_mode = 1'b0;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
	logic [31:0] i_wdata = 32'h00000000;
	logic [7:0] i_core_result = 8'h00;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample, o_core_tick;
	logic o_ref_high_sel, o_ref_low_sel, o_power_down, o_irq;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [4:0] o_input_select;
	logic [7:0] o_pin_override;
	int osc_cnt = 0, err_total = 0, total_checks = 0, gap, sample_cnt = 0, s0;
	logic [7:0] sel_codes [6] = '{8'h00, 8'h03, 8'h07, 8'h1D, 8'h1E, 8'h1F};

	adcsq_top adcsq_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.i_osc_tick(i_osc_tick), .i_stop_mode(i_stop_mode), .o_sample(o_sample),
		.o_core_tick(o_core_tick), .o_input_select(o_input_select),
		.o_ref_high_sel(o_ref_high_sel), .o_ref_low_sel(o_ref_low_sel),
		.o_power_down(o_power_down), .i_core_result(i_core_result),
		.o_pin_override(o_pin_override), .o_irq(o_irq));

	// Clock and a free-running oscillator tick, one pulse every OSC_PER cycles
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		osc_cnt <= (osc_cnt == OSC_PER - 1) ? 0 : osc_cnt + 1;
		i_osc_tick <= (osc_cnt == OSC_PER - 1);
	end

	// Sampling strobes seen; one per conversion started
	always @(posedge i_clk) begin
		if (o_sample === 1'b1) begin
			sample_cnt <= sample_cnt + 1;
		end
	end

	// ****************************************
	// Compare and bus tasks
	// ****************************************
	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk32

	task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s response expected %h seen %h", nm, exp, got);
		end
	endtask : chk_resp

	// Address and data offered together, each dropped at its own handshake edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aw_ok;
		bit w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		n = 0;
		i_awaddr <= a;
		i_awvalid <= 1'b1;
		i_wdata <= {24'h000000, d};
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 100) begin
			@(posedge i_clk);
			n++;
			if (!aw_ok && o_awready === 1'b1) begin
				aw_ok = 1;
				i_awvalid <= 1'b0;
			end
			if (!w_ok && o_wready === 1'b1) begin
				w_ok = 1;
				i_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge i_clk);
			n++;
		end while (o_bvalid !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_total++;
			$display("CHECK FAILED write answer expected bvalid seen timeout");
		end
		chk_resp("write", er, o_bresp);
		i_bready <= 1'b0;
		// Extra edge so no strobe is assigned twice in one step
		@(posedge i_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er,
		input string nm);
		int n;
		n = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_arready !== 1'b1 && n < 100);
		i_arvalid <= 1'b0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_rvalid !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_total++;
			$display("CHECK FAILED read answer expected rvalid seen timeout");
		end
		chk32(nm, exp, o_rdata);
		chk_resp(nm, er, o_rresp);
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask : rd

	// Cycles between two converter ticks, sampled where they have settled
	task automatic tick_gap(output int g);
		int n;
		n = 0;
		g = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (o_core_tick !== 1'b1 && n < 200);
		do begin
			@(negedge i_clk);
			g++;
		end while (o_core_tick !== 1'b1 && g < 200);
		@(posedge i_clk);
	endtask : tick_gap

	task automatic do_reset();
		i_reset_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
	endtask : do_reset

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		do_reset();
		rd(ADCSQ_OFF_CTRL, 32'h0000001F, ADCSQ_RESP_OKAY, "ctrl reset");
		rd(ADCSQ_OFF_CLKCFG, 32'h00000000, ADCSQ_RESP_OKAY, "clkcfg reset");
		rd(4'hC, 32'h00000000, ADCSQ_RESP_SLVERR, "unmapped read");
		wr(4'hC, 8'h55, ADCSQ_RESP_SLVERR);
		$display("test reset values done");
		// Every prescaler code, bus source; the top bit alone decides divide by 16
		for (int c = 0; c < 8; c++) begin
			wr(ADCSQ_OFF_CLKCFG, {c[2:0], 5'h10}, ADCSQ_RESP_OKAY);
			rd(ADCSQ_OFF_CLKCFG, {24'h0, c[2:0], 5'h10}, ADCSQ_RESP_OKAY, "clkcfg rw");
			wr(ADCSQ_OFF_CTRL, 8'h01, ADCSQ_RESP_OKAY);
			tick_gap(gap);
			chk32("tick gap", c[2] ? 16 : (1 << c[1:0]), gap);
		end
		// Oscillator source divided by 2, a converter tick every 2*OSC_PER cycles
		wr(ADCSQ_OFF_CLKCFG, 8'h20, ADCSQ_RESP_OKAY);
		wr(ADCSQ_OFF_CTRL, 8'h01, ADCSQ_RESP_OKAY);
		tick_gap(gap);
		chk32("osc tick gap", 2 * OSC_PER, gap);
		$display("test prescaler done");
		// Single conversion in flag mode; exactly one sampling strobe
		wr(ADCSQ_OFF_CLKCFG, 8'h10, ADCSQ_RESP_OKAY);
		i_core_result <= 8'hA5;
		s0 = sample_cnt;
		wr(ADCSQ_OFF_CTRL, 8'h03, ADCSQ_RESP_OKAY);
		repeat (30) @(posedge i_clk);
		chk32("sample strobes", 32'h1, sample_cnt - s0);
		chk32("pin override", 32'h08, o_pin_override);
		rd(ADCSQ_OFF_CTRL, 32'h83, ADCSQ_RESP_OKAY, "done set");
		rd(ADCSQ_OFF_RESULT, 32'hA5, ADCSQ_RESP_OKAY, "result");
		rd(ADCSQ_OFF_CTRL, 32'h03, ADCSQ_RESP_OKAY, "done cleared by read");
		repeat (40) @(posedge i_clk);
		rd(ADCSQ_OFF_CTRL, 32'h03, ADCSQ_RESP_OKAY, "one conversion only");
		chk32("one sample only", 32'h1, sample_cnt - s0);
		wr(ADCSQ_OFF_CTRL, 8'h03, ADCSQ_RESP_OKAY);
		repeat (30) @(posedge i_clk);
		do_reset();
		rd(ADCSQ_OFF_CTRL, 32'h1F, ADCSQ_RESP_OKAY, "done cleared by reset");
		$display("test single done");
		// Interrupt mode: flag stays 0, request cleared by read or control write
		wr(ADCSQ_OFF_CLKCFG, 8'h10, ADCSQ_RESP_OKAY);
		wr(ADCSQ_OFF_CTRL, 8'h41, ADCSQ_RESP_OKAY);
		repeat (30) @(posedge i_clk);
		chk32("irq raised", 32'h1, o_irq);
		rd(ADCSQ_OFF_CTRL, 32'h41, ADCSQ_RESP_OKAY, "flag masked");
		rd(ADCSQ_OFF_RESULT, 32'hA5, ADCSQ_RESP_OKAY, "irq result");
		chk32("irq cleared by read", 32'h0, o_irq);
		wr(ADCSQ_OFF_CTRL, 8'h41, ADCSQ_RESP_OKAY);
		repeat (30) @(posedge i_clk);
		chk32("irq again", 32'h1, o_irq);
		wr(ADCSQ_OFF_CTRL, 8'h5F, ADCSQ_RESP_OKAY);
		chk32("irq cleared by write", 32'h0, o_irq);
		$display("test interrupt done");
		// Continuous mode overwrites the result after each conversion
		i_core_result <= 8'h11;
		wr(ADCSQ_OFF_CTRL, 8'h25, ADCSQ_RESP_OKAY);
		repeat (30) @(posedge i_clk);
		rd(ADCSQ_OFF_RESULT, 32'h11, ADCSQ_RESP_OKAY, "cont result 1");
		i_core_result <= 8'h22;
		repeat (30) @(posedge i_clk);
		rd(ADCSQ_OFF_RESULT, 32'h22, ADCSQ_RESP_OKAY, "cont result 2");
		wr(ADCSQ_OFF_CTRL, 8'h1F, ADCSQ_RESP_OKAY);
		// A conversion may have ended before the stop; its flag is read away
		rd(ADCSQ_OFF_RESULT, 32'h22, ADCSQ_RESP_OKAY, "cont stopped");
		$display("test continuous done");
		// Control write mid-conversion restarts with the new selector
		wr(ADCSQ_OFF_CLKCFG, 8'h90, ADCSQ_RESP_OKAY);
		wr(ADCSQ_OFF_CTRL, 8'h02, ADCSQ_RESP_OKAY);
		repeat (50) @(posedge i_clk);
		wr(ADCSQ_OFF_CTRL, 8'h04, ADCSQ_RESP_OKAY);
		chk32("new selector", 32'h04, o_input_select);
		repeat (225) @(posedge i_clk);
		rd(ADCSQ_OFF_CTRL, 32'h04, ADCSQ_RESP_OKAY, "restart not done");
		repeat (60) @(posedge i_clk);
		rd(ADCSQ_OFF_CTRL, 32'h84, ADCSQ_RESP_OKAY, "restart done");
		// Only the restarted result is taken; the interrupted one is never read
		rd(ADCSQ_OFF_RESULT, 32'h22, ADCSQ_RESP_OKAY, "restart result");
		$display("test restart done");
		// Stop mode aborts, then a fresh conversion completes after exit
		wr(ADCSQ_OFF_CLKCFG, 8'h10, ADCSQ_RESP_OKAY);
		wr(ADCSQ_OFF_CTRL, 8'h01, ADCSQ_RESP_OKAY);
		repeat (6) @(posedge i_clk);
		i_stop_mode <= 1'b1;
		repeat (40) @(posedge i_clk);
		chk32("stop power down", 32'h1, o_power_down);
		rd(ADCSQ_OFF_CTRL, 32'h01, ADCSQ_RESP_OKAY, "aborted");
		i_stop_mode <= 1'b0;
		repeat (30) @(posedge i_clk);
		rd(ADCSQ_OFF_CTRL, 32'h81, ADCSQ_RESP_OKAY, "resumed");
		$display("test stop done");
		// Selector decode: external pins, references, power off
		foreach (sel_codes[k]) begin
			wr(ADCSQ_OFF_CTRL, sel_codes[k], ADCSQ_RESP_OKAY);
			chk32("select", sel_codes[k], o_input_select);
			chk32("override", (sel_codes[k] < 8) ? (1 << sel_codes[k]) : 0, o_pin_override);
			chk32("ref high", sel_codes[k] == 8'h1D, o_ref_high_sel);
			chk32("ref low", sel_codes[k] == 8'h1E, o_ref_low_sel);
			chk32("power down", sel_codes[k] == 8'h1F, o_power_down);
		end
		$display("test selector done");
		stop_test();
	end

	// Watchdog: the tests need about a thousand cycles, so 20000 means a hang
	initial begin
		#200000;
		err_total++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		stop_test();
	end
endmodule : adcsq_top_tb
